/* File: inc/asr_pkg.sv */
// constants and types for the asynchronous byte-wide static memory controller
package asr_pkg;

    // system clock period
    localparam int CLK_PERIOD_NS = 20;

    // memory geometry
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;

    // timing figures in ns, fast grade
    localparam int T_RC_FAST_NS  = 70;  // read cycle, also address access
    localparam int T_AA_FAST_NS  = 70;
    localparam int T_CW_FAST_NS  = 60;
    localparam int T_AW_FAST_NS  = 60;
    localparam int T_WP_FAST_NS  = 50;
    localparam int T_DW_FAST_NS  = 30;
    localparam int T_HZ_FAST_NS  = 30;  // release of the bus by the memory
    localparam int T_WC_FAST_NS  = 70;

    // timing figures in ns, slow grade
    localparam int T_RC_SLOW_NS  = 85;
    localparam int T_AA_SLOW_NS  = 85;
    localparam int T_CW_SLOW_NS  = 75;
    localparam int T_AW_SLOW_NS  = 75;
    localparam int T_WP_SLOW_NS  = 55;
    localparam int T_DW_SLOW_NS  = 35;
    localparam int T_HZ_SLOW_NS  = 35;
    localparam int T_WC_SLOW_NS  = 85;

    // least times round up to whole cycles
    function automatic int ns_to_min_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max4(input int a, input int b, input int c, input int d);
        int m;
        m = (a > b) ? a : b;
        m = (m > c) ? m : c;
        return (m > d) ? m : d;
    endfunction

    // read strobe time: access time and cycle time both met
    localparam int RD_CYC_FAST = ns_to_min_cyc((T_AA_FAST_NS > T_RC_FAST_NS) ?
                                               T_AA_FAST_NS : T_RC_FAST_NS);
    localparam int RD_CYC_SLOW = ns_to_min_cyc((T_AA_SLOW_NS > T_RC_SLOW_NS) ?
                                               T_AA_SLOW_NS : T_RC_SLOW_NS);
    // write low time: pulse, select, address and data windows all met
    localparam int WR_CYC_FAST = ns_to_min_cyc(max4(T_CW_FAST_NS, T_AW_FAST_NS,
                                                    T_WP_FAST_NS, T_DW_FAST_NS));
    localparam int WR_CYC_SLOW = ns_to_min_cyc(max4(T_CW_SLOW_NS, T_AW_SLOW_NS,
                                                    T_WP_SLOW_NS, T_DW_SLOW_NS));
    // write cycle total, the closing cycle counted in
    localparam int WC_CYC_FAST = ns_to_min_cyc(T_WC_FAST_NS);
    localparam int WC_CYC_SLOW = ns_to_min_cyc(T_WC_SLOW_NS);
    // bus turnaround after a read
    localparam int HZ_CYC_FAST = ns_to_min_cyc(T_HZ_FAST_NS);
    localparam int HZ_CYC_SLOW = ns_to_min_cyc(T_HZ_SLOW_NS);

    // counter width
    localparam int CNT_W = 4;

    // controller states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_READ  = 7'h02,
        ST_TURN  = 7'h04,
        ST_WRITE = 7'h08,
        ST_WEND  = 7'h10,
        ST_STBY  = 7'h20,
        ST_RECOV = 7'h40
    } asr_state_t;

endpackage

/* File: logic/asr_ctrl.sv */
// host-side controller that drives an asynchronous byte-wide static memory
`timescale 1ns/1ns

module asr_ctrl
    import asr_pkg::*;
#(
    parameter bit FAST_GRADE = 1'b1
) (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                resetn,
    // user request port
    input  wire logic                req_valid,
    input  wire logic                req_write,
    input  wire logic [ADDR_W-1:0]   req_addr,
    input  wire logic [DATA_W-1:0]   req_wdata,
    output logic                     req_ready,
    // read answer
    output logic                     rd_valid,
    output logic [DATA_W-1:0]        rd_data,
    // retention standby
    input  wire logic                standby_req,
    output logic                     standby_active,
    // memory pins
    output logic [ADDR_W-1:0]        byte_address,
    output logic                     cs_n,
    output logic                     oe_n,
    output logic                     we_n,
    input  wire logic [DATA_W-1:0]   data_bus_in,
    output logic [DATA_W-1:0]        data_bus_out,
    output logic                     data_bus_oe
);

    // grade-dependent counts, minus one for a down counter ending at zero
    localparam logic [CNT_W-1:0] RD_LAST =
        CNT_W'((FAST_GRADE ? RD_CYC_FAST : RD_CYC_SLOW) - 1);
    localparam int WR_LOW = FAST_GRADE ? WR_CYC_FAST : WR_CYC_SLOW;
    localparam int WC_ALL = FAST_GRADE ? WC_CYC_FAST : WC_CYC_SLOW;
    // closing cycle included; stretch the low time if the cycle time demands it
    localparam logic [CNT_W-1:0] WR_LAST =
        CNT_W'(((WR_LOW + 1 > WC_ALL) ? WR_LOW : WC_ALL - 1) - 1);
    localparam logic [CNT_W-1:0] HZ_LAST =
        CNT_W'((FAST_GRADE ? HZ_CYC_FAST : HZ_CYC_SLOW) - 1);
    localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(0);

    asr_state_t             state;
    asr_state_t             next_state;
    logic [CNT_W-1:0]       cnt;
    logic [CNT_W-1:0]       next_cnt;
    logic                   accept;

    // requests only taken when idle and no standby is pending
    assign req_ready = (state == ST_IDLE) && !standby_req;
    assign accept    = req_ready && req_valid;

    // sequencing of strobe phases
    always_comb begin
        next_state = state;
        next_cnt   = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - CNT_W'(1);
        case (state)
            ST_IDLE: begin
                // standby wins over requests
                // a pending request simply waits out the standby
                if (standby_req) begin
                    next_state = ST_STBY;
                end else if (accept && req_write) begin
                    next_state = ST_WRITE;
                    next_cnt   = WR_LAST;
                end else if (accept) begin
                    next_state = ST_READ;
                    next_cnt   = RD_LAST;
                end
            end
            ST_READ: begin
                // hold strobes for full access time
                if (cnt == CNT_ZERO) begin
                    next_state = ST_TURN;
                    next_cnt   = HZ_LAST;
                end
            end
            ST_TURN: begin
                // wait out the memory's float time
                // costs two idle cycles even between two reads
                if (cnt == CNT_ZERO) begin
                    next_state = ST_IDLE;
                end
            end
            ST_WRITE: begin
                if (cnt == CNT_ZERO) begin
                    next_state = ST_WEND;
                end
            end
            ST_WEND: begin
                next_state = ST_IDLE;
            end
            ST_STBY: begin
                if (!standby_req) begin
                    next_state = ST_RECOV;
                    next_cnt   = RD_LAST;
                end
            end
            ST_RECOV: begin
                // one read cycle before new access
                if (cnt == CNT_ZERO) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_cnt   = CNT_ZERO;
            end
        endcase
    end

    // state and phase counter
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            cnt   <= CNT_ZERO;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // address and write data latched at acceptance, held until the next one
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            byte_address <= '0;
            data_bus_out <= '0;
        end else if (accept) begin
            // address set with the strobes, held through
            byte_address <= req_addr;
            data_bus_out <= req_wdata;
        end
    end

    // strobes registered from the next state so pins never glitch
    // no cycle of latency paid: pins change on the same edge as the state, with clean, skew-free edges
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cs_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
        end else begin
            // select and write enable fall together
            // select low across the whole write
            cs_n <= !((next_state == ST_READ) || (next_state == ST_WRITE));
            // output enable kept high while writing
            oe_n <= !(next_state == ST_READ);
            // both strobes rise together at write end
            we_n <= !(next_state == ST_WRITE);
        end
    end

    // bus drive: write phases only, data kept one cycle past the strobes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            data_bus_oe <= 1'b0;
        end else begin
            // never driven in read or turnaround
            // data stays through the closing cycle
            data_bus_oe <= (next_state == ST_WRITE) || (next_state == ST_WEND);
        end
    end

    // read capture at the end of the access wait
    // limitation: a memory that never drove still yields a byte
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else begin
            rd_valid <= 1'b0;
            // output enable asserted from read start
            if ((state == ST_READ) && (cnt == CNT_ZERO)) begin
                rd_valid <= 1'b1;
                rd_data  <= data_bus_in;
            end
        end
    end

    // standby indication, a level that follows the state
    // recovery time is held by the state machine, not here
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            standby_active <= 1'b0;
        end else begin
            standby_active <= (next_state == ST_STBY);
        end
    end

endmodule

/* File: test/asr_ctrl_chk.sv */
// pin-level checks of the static memory controller
`timescale 1ns/1ns
module asr_ctrl_chk
    import asr_pkg::*;
#(
    parameter bit FAST_GRADE = 1'b1
) (
    // clock and reset
    input wire logic              sys_clk,
    input wire logic              resetn,
    // memory pins
    input wire logic [ADDR_W-1:0] byte_address,
    input wire logic              cs_n,
    input wire logic              oe_n,
    input wire logic              we_n,
    input wire logic [DATA_W-1:0] data_bus_in,
    input wire logic [DATA_W-1:0] data_bus_out,
    input wire logic              data_bus_oe,
    // user side
    input wire logic              rd_valid,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic              standby_active
);
    // counts below are fast-grade cycle figures
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    property p_wr_pulse; $fell(we_n) |-> (!we_n && !cs_n) [*3] ##1 (we_n && cs_n); endproperty
    a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse too short");
    property p_wr_end; $rose(we_n) |-> $rose(cs_n); endproperty
    a_wr_end: assert property (p_wr_end) else $error("write end strobes split");
    property p_wr_hold; $rose(we_n) |-> data_bus_oe ##1 !data_bus_oe; endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write data not held");
    property p_wr_steady; !we_n && $past(!we_n) |-> $stable(byte_address) && $stable(data_bus_out); endproperty
    a_wr_steady: assert property (p_wr_steady) else $error("address or data moved");
    property p_wr_start; $fell(we_n) |-> $fell(cs_n) && oe_n && data_bus_oe; endproperty
    a_wr_start: assert property (p_wr_start) else $error("bad write start");
    property p_turn; $rose(oe_n) |-> !data_bus_oe [*2]; endproperty
    a_turn: assert property (p_turn) else $error("drive during turnaround");
    property p_rd_len; $fell(oe_n) |-> (!oe_n && !cs_n && we_n) [*4] ##1 (oe_n && cs_n); endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe length");
    property p_rd_data; $fell(oe_n) |-> ##4 rd_valid && rd_data == $past(data_bus_in); endproperty
    a_rd_data: assert property (p_rd_data) else $error("read capture wrong");
    property p_stby; standby_active |-> cs_n && we_n && !data_bus_oe; endproperty
    a_stby: assert property (p_stby) else $error("pins active in standby");
    property p_recov; $fell(standby_active) |-> cs_n [*3]; endproperty
    a_recov: assert property (p_recov) else $error("early access after standby");
endmodule

/* File: test/asr_mem_model.sv */
// behavioural byte-wide static memory on the far side of the controller
`timescale 1ns/1ns
module asr_mem_model
    import asr_pkg::*;
#(
    parameter int ACC_NS = 70
) (
    // memory pins
    input  wire logic [ADDR_W-1:0] byte_address,
    input  wire logic              cs_n,
    input  wire logic              oe_n,
    input  wire logic              we_n,
    // shared data wire
    input  wire logic [DATA_W-1:0] data_bus_out,
    input  wire logic              data_bus_oe,
    output logic      [DATA_W-1:0] data_bus_in
);
    // sparse store, unwritten bytes read unknown
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] last;
    logic              rd_sel, rd_late, rd_on, wr_open;
    logic [ADDR_W-1:0] addr_late;
    // drive late on a read, release at once
    // never drives before the full access time
    // write enable low ends the drive at once
    assign rd_sel = !cs_n && !oe_n && we_n;
    assign #(ACC_NS) rd_late = rd_sel;
    // an address move restarts the access; old byte not kept, stricter
    assign #(ACC_NS) addr_late = byte_address;
    assign rd_on = rd_sel && rd_late && (addr_late === byte_address);
    // released wire shows the inverse, never a held copy
    always @(rd_on, byte_address, data_bus_oe, data_bus_out) begin
        if (rd_on)
            last = mem[byte_address];
        else if (data_bus_oe)
            last = data_bus_out;
    end
    assign data_bus_in = (rd_on || data_bus_oe) ? last : ~last;
    // write opens at the later falling strobe
    // commit at first rising strobe; standby keeps contents
    always @(cs_n, we_n) begin
        if (!cs_n && !we_n) begin
            wr_open = 1'b1;
        end else if (wr_open === 1'b1) begin
            mem[byte_address] = data_bus_in;
            wr_open = 1'b0;
        end
    end
endmodule

/* File: test/tb_asr_ctrl.sv */
// self-checking bench for the static memory controller
`timescale 1ns/1ns
module tb_asr_ctrl;
    import asr_pkg::*;
    logic              sys_clk, resetn, req_valid, req_write, standby_req, req_ready;
    logic              rd_valid, standby_active, cs_n, oe_n, we_n, data_bus_oe;
    logic [ADDR_W-1:0] req_addr, byte_address;
    logic [DATA_W-1:0] req_wdata, rd_data, data_bus_in, data_bus_out;
    int                fails, cmp_count;

    asr_ctrl #(.FAST_GRADE(1'b1)) i_dut (.sys_clk, .resetn, .req_valid, .req_write, .req_addr,
        .req_wdata, .req_ready, .rd_valid, .rd_data, .standby_req, .standby_active,
        .byte_address, .cs_n, .oe_n, .we_n, .data_bus_in, .data_bus_out, .data_bus_oe);
    asr_mem_model #(.ACC_NS(T_AA_FAST_NS)) i_mem (.byte_address, .cs_n, .oe_n, .we_n,
        .data_bus_out, .data_bus_oe,
        .data_bus_in);

    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // request held until taken, bounded wait
    task automatic request(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        check(req_ready, 1'b1);
        req_valid <= 1'b0;
    endtask

    // read answer due five edges after the take
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        int n;
        n = 0;
        request(1'b0, a, 8'h00);
        while (rd_valid !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        check(n, 5);
        check(rd_data, e);
    endtask

    // extreme and patterned addresses, then an overwrite read back at once
    task automatic sc_rw;
        logic [ADDR_W-1:0] a [4] = '{19'h00000, 19'h7FFFF, 19'h12345, 19'h2AAAA};
        logic [DATA_W-1:0] d [4] = '{8'hA5, 8'h5A, 8'h00, 8'hFF};
        foreach (a[i]) request(1'b1, a[i], d[i]);
        foreach (a[i]) rd(a[i], d[i]);
        request(1'b1, 19'h12345, 8'h3C);
        rd(19'h12345, 8'h3C);
    endtask

    // standby refuses requests, keeps data, recovers before access
    task automatic sc_standby;
        int n;
        n = 0;
        @(posedge sys_clk);
        standby_req <= 1'b1;
        repeat (3) @(posedge sys_clk);
        check(standby_active, 1'b1);
        check(req_ready, 1'b0);
        standby_req <= 1'b0;
        while (req_ready !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        check(req_ready, 1'b1);
        check(n >= 4, 1'b1);
        rd(19'h7FFFF, 8'h5A);
    endtask

    task automatic report_and_stop;
        if (fails == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // main sequence
    initial begin
        resetn = 1'b0;
        {req_valid, req_write, standby_req} = 3'h0;
        req_addr = '0;
        req_wdata = '0;
        fails = 0;
        cmp_count = 0;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        check({cs_n, oe_n, we_n, data_bus_oe}, 4'hE);
        sc_rw();
        sc_standby();
        report_and_stop();
    end

    // watchdog, far beyond the roughly 90 cycles expected
    initial begin
        repeat (3000) @(posedge sys_clk);
        fails++;
        report_and_stop();
    end
endmodule

bind asr_ctrl asr_ctrl_chk #(.FAST_GRADE(FAST_GRADE)) i_chk (.sys_clk, .resetn, .byte_address,
    .cs_n, .oe_n, .we_n, .data_bus_in, .data_bus_out, .data_bus_oe, .rd_valid, .rd_data,
    .standby_active);
